//--- include/spl_pkg.sv
/*
 * Shared constants and carrier types for the serial-receiver register bank:
 * register offsets, field positions, reset values and the access carrier.
 * Assumes a single register clock and an 8-bit byte-wide register port.
 */
package spl_pkg;

    // ************************************************************
    // widths
    // ************************************************************
    localparam int unsigned SPL_AW = 12;
    localparam int unsigned SPL_DW = 8;

    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [11:0] SPL_OFS_VCO_BIAS_A   = 12'h296;
    localparam logic [11:0] SPL_OFS_VCO_BIAS_B   = 12'h297;
    localparam logic [11:0] SPL_OFS_VCO_PD_OVR   = 12'h299;
    localparam logic [11:0] SPL_OFS_VCO_CALIBRATION_CTRL      = 12'h29A;
    localparam logic [11:0] SPL_OFS_PUMP_LVL     = 12'h29C;
    localparam logic [11:0] SPL_OFS_VARAC_A      = 12'h29F;
    localparam logic [11:0] SPL_OFS_VARAC_B      = 12'h2A0;
    localparam logic [11:0] SPL_OFS_TERM_A       = 12'h2A7;
    localparam logic [11:0] SPL_OFS_TERM_B       = 12'h2AE;
    localparam logic [11:0] SPL_OFS_GEN_A        = 12'h300;
    localparam logic [11:0] SPL_OFS_GEN_B        = 12'h301;
    localparam logic [11:0] SPL_OFS_LAT_A        = 12'h302;

    // ************************************************************
    // reset values and writable masks (reserved bits read zero)
    // ************************************************************
    localparam logic [7:0] SPL_RST_VCO_BIAS_A = 8'h0C;
    localparam logic [7:0] SPL_MSK_VCO_BIAS_A = 8'hFF;
    localparam logic [7:0] SPL_RST_VCO_BIAS_B = 8'h00;
    localparam logic [7:0] SPL_MSK_VCO_BIAS_B = 8'h3F;
    localparam logic [7:0] SPL_RST_VCO_PD_OVR = 8'h00;
    localparam logic [7:0] SPL_MSK_VCO_PD_OVR = 8'hFF;
    localparam logic [7:0] SPL_RST_VCO_CALIBRATION_CTRL    = 8'hFE;
    localparam logic [7:0] SPL_MSK_VCO_CALIBRATION_CTRL    = 8'hFF;
    localparam logic [7:0] SPL_RST_PUMP_LVL   = 8'h17;
    localparam logic [7:0] SPL_MSK_PUMP_LVL   = 8'h7F;
    localparam logic [7:0] SPL_RST_VARAC_A    = 8'h33;
    localparam logic [7:0] SPL_MSK_VARAC_A    = 8'h7F;
    localparam logic [7:0] SPL_RST_VARAC_B    = 8'h08;
    localparam logic [7:0] SPL_MSK_VARAC_B    = 8'h0F;
    localparam logic [7:0] SPL_RST_TERM       = 8'h00;
    localparam logic [7:0] SPL_MSK_TERM       = 8'h01;
    localparam logic [7:0] SPL_RST_GEN_A      = 8'h00;
    localparam logic [7:0] SPL_MSK_GEN_A      = 8'h7F;
    localparam logic [7:0] SPL_RST_GEN_B      = 8'h01;
    localparam logic [7:0] SPL_MSK_GEN_B      = 8'h07;
    localparam logic [7:0] SPL_MSK_LAT        = 8'h1F;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int unsigned SPL_BIT_TERM_TRIG  = 0;
    localparam int unsigned SPL_BIT_SUM_METHOD = 6;
    localparam int unsigned SPL_BIT_TWO_LINK   = 3;
    localparam int unsigned SPL_BIT_BANK_SEL   = 2;
    localparam int unsigned SPL_BIT_LINK0_EN   = 0;
    localparam int unsigned SPL_BIT_LINK1_EN   = 1;
    localparam int unsigned SPL_LAT_W          = 5;
    localparam int unsigned SPL_CLASS_W        = 3;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [11:0] addr;
        logic [7:0]  wdata;
    } spl_req_t;

    typedef struct packed {
        logic       param_sum_method;
        logic       two_link_select;
        logic       bank_select;
        logic [1:0] link_bringup_bits;
        logic [2:0] local_latency_class;
    } spl_link_cfg_t;

endpackage

//--- rtl/spl_rise_pulse.sv
/*
 * Rising-edge detector: one-cycle pulse on a zero-to-one step of a
 * register bit. Assumes the input is on the same clock as this module.
 */
module spl_rise_pulse (
    input  wire logic i_clk,
    input  wire logic i_sys_rst,
    input  wire logic i_level,
    output logic      o_pulse
);

    logic level_r;

    // remember last level so a held-high bit never retriggers
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            level_r <= 1'b0;
        end else begin
            level_r <= i_level;
        end
    end

    assign o_pulse = i_level & ~level_r;

endmodule

//--- rtl/spl_regs.sv
/*
 * Serial-receiver configuration register bank: PLL trim fields, two
 * termination calibration triggers, link general controls and the
 * read-only measured link delay.
 * Assumes the serial programming port has already been deserialised into
 * byte-wide single-cycle write/read strobes on i_clk.
 */
// Operation
// - rising edge of a termination trigger bit launches one calibration
// - sum-method bit: 0 sums parameter fields, 1 sums configuration octets
// - link-count bit: 0 single link, 1 two independent links
// - bank-select bit steers per-link bank accesses to first or second bank
// - link enable bit 0 brings up link one, bit 1 link two
// - second link enable acts only in dual mode; links enable independently
// - first link delay register is read-only; writes are ignored
// - delay gives five-bit offset of local to global multiframe clock
module spl_regs (
    input  wire logic                        i_clk,
    input  wire logic                        i_sys_rst,
    input  wire spl_pkg::spl_req_t           i_req,
    output logic [7:0]                       o_rdata,
    output logic                             o_rvalid,
    input  wire logic [spl_pkg::SPL_LAT_W-1:0] i_measured_link_delay,
    output logic                             o_term_cal_start_a,
    output logic                             o_term_cal_start_b,
    output spl_pkg::spl_link_cfg_t           o_link_cfg,
    output logic                             o_link0_run,
    output logic                             o_link1_run,
    output logic                             o_first_link_bank,
    output logic                             o_second_link_bank,
    output logic                             o_class1_rules,
    output logic [63:0]                      o_pll_trim
);
    import spl_pkg::*;

    // the delay byte layout below pads a field of exactly five bits
    if (SPL_LAT_W != 5) begin : g_lat_w_chk
        $error("measured delay width must be five bits");
    end

    // ************************************************************
    // storage
    // ************************************************************
    logic [7:0] vco_bias_ctrl_a_r;
    logic [7:0] vco_bias_ctrl_b_r;
    logic [7:0] vco_powerdown_overrides_r;
    logic [7:0] vco_calibration_ctrl_r;
    logic [7:0] pump_level_detector_r;
    logic [7:0] varactor_ctrl_a_r;
    logic [7:0] varactor_ctrl_b_r;
    logic [7:0] termination_cal_a_r;
    logic [7:0] termination_cal_b_r;
    logic [7:0] link_general_ctrl_a_r;
    logic [7:0] link_general_ctrl_b_r;
    logic [7:0] rdata_r;
    logic       rvalid_r;
    logic [SPL_LAT_W-1:0] delay_r;

    // ************************************************************
    // address decode
    // ************************************************************
    function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
        hit = (a == o);
    endfunction

    // merge a write byte into a register through its writable mask
    function automatic logic [7:0] wmask(input logic [7:0] d,
                                         input logic [7:0] m);
        wmask = d & m;
    endfunction

    wire wr = i_req.wr;
    wire [11:0] ad = i_req.addr;
    wire [7:0] wd = i_req.wdata;
    wire we_bias_a = wr & hit(ad, SPL_OFS_VCO_BIAS_A);
    wire we_bias_b = wr & hit(ad, SPL_OFS_VCO_BIAS_B);
    wire we_pd_ovr = wr & hit(ad, SPL_OFS_VCO_PD_OVR);
    wire we_vcocal = wr & hit(ad, SPL_OFS_VCO_CALIBRATION_CTRL);
    wire we_pump   = wr & hit(ad, SPL_OFS_PUMP_LVL);
    wire we_var_a  = wr & hit(ad, SPL_OFS_VARAC_A);
    wire we_var_b  = wr & hit(ad, SPL_OFS_VARAC_B);
    wire we_term_a = wr & hit(ad, SPL_OFS_TERM_A);
    wire we_term_b = wr & hit(ad, SPL_OFS_TERM_B);
    wire we_gen_a  = wr & hit(ad, SPL_OFS_GEN_A);
    wire we_gen_b  = wr & hit(ad, SPL_OFS_GEN_B);
    // no write strobe exists for the delay offset: it is status only

    // ************************************************************
    // writable registers
    // ************************************************************
    // pll trim fields: stored only, driven out to the analog side
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            vco_bias_ctrl_a_r         <= SPL_RST_VCO_BIAS_A;
            vco_bias_ctrl_b_r         <= SPL_RST_VCO_BIAS_B;
            vco_powerdown_overrides_r <= SPL_RST_VCO_PD_OVR;
            vco_calibration_ctrl_r    <= SPL_RST_VCO_CALIBRATION_CTRL;
            pump_level_detector_r     <= SPL_RST_PUMP_LVL;
            varactor_ctrl_a_r         <= SPL_RST_VARAC_A;
            varactor_ctrl_b_r         <= SPL_RST_VARAC_B;
        end else begin
            if (we_bias_a) begin
                vco_bias_ctrl_a_r <= wmask(wd, SPL_MSK_VCO_BIAS_A);
            end
            if (we_bias_b) begin
                vco_bias_ctrl_b_r <= wmask(wd, SPL_MSK_VCO_BIAS_B);
            end
            if (we_pd_ovr) begin
                vco_powerdown_overrides_r <= wmask(wd, SPL_MSK_VCO_PD_OVR);
            end
            if (we_vcocal) begin
                vco_calibration_ctrl_r <= wmask(wd, SPL_MSK_VCO_CALIBRATION_CTRL);
            end
            if (we_pump) begin
                pump_level_detector_r <= wmask(wd, SPL_MSK_PUMP_LVL);
            end
            if (we_var_a) begin
                varactor_ctrl_a_r <= wmask(wd, SPL_MSK_VARAC_A);
            end
            if (we_var_b) begin
                varactor_ctrl_b_r <= wmask(wd, SPL_MSK_VARAC_B);
            end
        end
    end

    // termination triggers and link controls
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            termination_cal_a_r   <= SPL_RST_TERM;
            termination_cal_b_r   <= SPL_RST_TERM;
            link_general_ctrl_a_r <= SPL_RST_GEN_A;
            link_general_ctrl_b_r <= SPL_RST_GEN_B;
        end else begin
            if (we_term_a) begin
                termination_cal_a_r <= wmask(wd, SPL_MSK_TERM);
            end
            if (we_term_b) begin
                termination_cal_b_r <= wmask(wd, SPL_MSK_TERM);
            end
            if (we_gen_a) begin
                link_general_ctrl_a_r <= wmask(wd, SPL_MSK_GEN_A);
            end
            if (we_gen_b) begin
                link_general_ctrl_b_r <= wmask(wd, SPL_MSK_GEN_B);
            end
        end
    end

    // ************************************************************
    // calibration launch
    // ************************************************************
    // edge detect means software must write 0 before it can re-launch
    spl_rise_pulse u_term_a (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_level   (termination_cal_a_r[SPL_BIT_TERM_TRIG]),
        .o_pulse   (o_term_cal_start_a)
    );

    spl_rise_pulse u_term_b (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_level   (termination_cal_b_r[SPL_BIT_TERM_TRIG]),
        .o_pulse   (o_term_cal_start_b)
    );

    // ************************************************************
    // link controls
    // ************************************************************
    // configuration fields to the receive logic
    assign o_link_cfg.param_sum_method    =
        link_general_ctrl_a_r[SPL_BIT_SUM_METHOD];
    assign o_link_cfg.two_link_select     =
        link_general_ctrl_a_r[SPL_BIT_TWO_LINK];
    assign o_link_cfg.bank_select         =
        link_general_ctrl_a_r[SPL_BIT_BANK_SEL];
    assign o_link_cfg.link_bringup_bits   = link_general_ctrl_a_r[1:0];
    assign o_link_cfg.local_latency_class =
        link_general_ctrl_b_r[SPL_CLASS_W-1:0];

    // bank steering for the per-link register map
    assign o_first_link_bank  =
        ~link_general_ctrl_a_r[SPL_BIT_BANK_SEL];
    assign o_second_link_bank =
        link_general_ctrl_a_r[SPL_BIT_BANK_SEL];

    // run enables; no ordering is enforced, software owns readiness
    assign o_link0_run = link_general_ctrl_a_r[SPL_BIT_LINK0_EN];
    assign o_link1_run = link_general_ctrl_a_r[SPL_BIT_LINK1_EN]
                       & link_general_ctrl_a_r[SPL_BIT_TWO_LINK];

    // deterministic-latency rules apply only for subclass 1
    assign o_class1_rules =
        (link_general_ctrl_b_r[SPL_CLASS_W-1:0] == 3'h1);

    assign o_pll_trim = {vco_bias_ctrl_a_r, vco_bias_ctrl_b_r,
                         vco_powerdown_overrides_r, vco_calibration_ctrl_r,
                         pump_level_detector_r, varactor_ctrl_a_r,
                         varactor_ctrl_b_r, 8'h00};

    // ************************************************************
    // read path
    // ************************************************************
    // sample measured delay each cycle; source is on i_clk already
    wire [7:0] lat_byte = {3'h0, delay_r} & SPL_MSK_LAT;
    logic [7:0] rmux;
    always_comb begin
        case (ad)
            SPL_OFS_VCO_BIAS_A: rmux = vco_bias_ctrl_a_r;
            SPL_OFS_VCO_BIAS_B: rmux = vco_bias_ctrl_b_r;
            SPL_OFS_VCO_PD_OVR: rmux = vco_powerdown_overrides_r;
            SPL_OFS_VCO_CALIBRATION_CTRL:    rmux = vco_calibration_ctrl_r;
            SPL_OFS_PUMP_LVL:   rmux = pump_level_detector_r;
            SPL_OFS_VARAC_A:    rmux = varactor_ctrl_a_r;
            SPL_OFS_VARAC_B:    rmux = varactor_ctrl_b_r;
            SPL_OFS_TERM_A:     rmux = termination_cal_a_r;
            SPL_OFS_TERM_B:     rmux = termination_cal_b_r;
            SPL_OFS_GEN_A:      rmux = link_general_ctrl_a_r;
            SPL_OFS_GEN_B:      rmux = link_general_ctrl_b_r;
            SPL_OFS_LAT_A:      rmux = lat_byte;
            default:            rmux = 8'h00;    // unmapped reads zero
        endcase
    end

    // registered read data, one cycle after the strobe
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rdata_r  <= 8'h00;
            rvalid_r <= 1'b0;
            delay_r  <= '0;
        end else begin
            delay_r  <= i_measured_link_delay;
            rvalid_r <= i_req.rd;
            if (i_req.rd) rdata_r <= rmux;
        end
    end

    assign o_rdata  = rdata_r;
    assign o_rvalid = rvalid_r;

endmodule

//--- test/spl_regs_checker.sv
/*
 * Port-level assertions for the serial-receiver register bank.
 * Assumes it is bound to spl_regs and that reads of the delay byte are
 * never issued in the first two cycles after reset.
 */
module spl_regs_checker
    import spl_pkg::*;
(
    input wire logic                          i_clk,
    input wire logic                          i_sys_rst,
    input wire spl_pkg::spl_req_t             i_req,
    input wire logic [7:0]                    o_rdata,
    input wire logic                          o_rvalid,
    input wire logic [spl_pkg::SPL_LAT_W-1:0] i_measured_link_delay,
    input wire logic                          o_term_cal_start_a,
    input wire logic                          o_term_cal_start_b,
    input wire spl_pkg::spl_link_cfg_t        o_link_cfg,
    input wire logic                          o_link0_run,
    input wire logic                          o_link1_run,
    input wire logic                          o_first_link_bank,
    input wire logic                          o_second_link_bank,
    input wire logic                          o_class1_rules
);
    timeunit 1ns;
    timeprecision 1ns;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    // write to the first link-control byte, and a plain read of the delay
    sequence s_gen_a_wr;
        i_req.wr && i_req.addr == SPL_OFS_GEN_A;
    endsequence
    sequence s_lat_rd;
        i_req.rd && i_req.addr == SPL_OFS_LAT_A;
    endsequence

    a_term_a_once: assert property (o_term_cal_start_a |->
        $past(i_req.wr && i_req.addr == SPL_OFS_TERM_A && i_req.wdata[0])
        ##1 !o_term_cal_start_a) else $error("term a pulse bad");
    a_term_b_once: assert property (o_term_cal_start_b |->
        $past(i_req.wr && i_req.addr == SPL_OFS_TERM_B && i_req.wdata[0])
        ##1 !o_term_cal_start_b) else $error("term b pulse bad");
    a_sum_method: assert property (s_gen_a_wr |=>
        o_link_cfg.param_sum_method == $past(i_req.wdata[6]))
        else $error("sum method bit bad");
    a_link_count: assert property (s_gen_a_wr |=>
        o_link_cfg.two_link_select == $past(i_req.wdata[3]))
        else $error("link count bit bad");
    a_bank_steer: assert property (o_second_link_bank ==
        o_link_cfg.bank_select && o_first_link_bank != o_second_link_bank)
        else $error("bank steering bad");
    a_link0_run: assert property (s_gen_a_wr |=>
        o_link0_run == $past(i_req.wdata[0])) else $error("link0 run bad");
    a_link1_gate: assert property (o_link1_run ==
        (o_link_cfg.link_bringup_bits[1] && o_link_cfg.two_link_select))
        else $error("link1 gating bad");
    a_delay_read: assert property (s_lat_rd |=> o_rvalid &&
        o_rdata == {3'h0, $past(i_measured_link_delay, 2)})
        else $error("delay readback bad");
    a_class_flag: assert property (o_class1_rules ==
        (o_link_cfg.local_latency_class == 3'h1)) else $error("class flag bad");
    a_rvalid_time: assert property (o_rvalid == $past(i_req.rd))
        else $error("read valid timing bad");
endmodule

//--- test/spl_regs_test.sv
/*
 * Self-checking bench for the serial-receiver register bank.
 * Assumes the byte-wide strobe port of spl_regs and a 25 MHz clock.
 */
module spl_regs_test;
    timeunit 1ns;
    timeprecision 1ns;
    import spl_pkg::*;

    localparam logic [11:0] RA [12] = '{SPL_OFS_VCO_BIAS_A, SPL_OFS_VCO_BIAS_B,
        SPL_OFS_VCO_PD_OVR, SPL_OFS_VCO_CALIBRATION_CTRL, SPL_OFS_PUMP_LVL, SPL_OFS_VARAC_A,
        SPL_OFS_VARAC_B, SPL_OFS_TERM_A, SPL_OFS_TERM_B, SPL_OFS_GEN_A,
        SPL_OFS_GEN_B, SPL_OFS_LAT_A};
    localparam logic [7:0] RV [12] = '{SPL_RST_VCO_BIAS_A, SPL_RST_VCO_BIAS_B,
        SPL_RST_VCO_PD_OVR, SPL_RST_VCO_CALIBRATION_CTRL, SPL_RST_PUMP_LVL, SPL_RST_VARAC_A,
        SPL_RST_VARAC_B, SPL_RST_TERM, SPL_RST_TERM, SPL_RST_GEN_A,
        SPL_RST_GEN_B, 8'h00};
    localparam logic [7:0] RM [12] = '{SPL_MSK_VCO_BIAS_A, SPL_MSK_VCO_BIAS_B,
        SPL_MSK_VCO_PD_OVR, SPL_MSK_VCO_CALIBRATION_CTRL, SPL_MSK_PUMP_LVL, SPL_MSK_VARAC_A,
        SPL_MSK_VARAC_B, SPL_MSK_TERM, SPL_MSK_TERM, SPL_MSK_GEN_A,
        SPL_MSK_GEN_B, 8'h00};

    logic            i_clk = 1'b0;
    logic            i_sys_rst = 1'b1;
    spl_req_t        req = '0;
    logic [4:0]      dly = 5'h00;
    logic [7:0]      o_rdata;
    logic            o_rvalid;
    logic [1:0]      pul;
    spl_link_cfg_t   o_link_cfg;
    logic            run0, run1, bank0, bank1, cls1;
    logic [63:0]     trim;
    int              fails = 0;
    int              cmp_count = 0;

    always #20 i_clk = ~i_clk;

    spl_regs i_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_req(req),
        .o_rdata(o_rdata), .o_rvalid(o_rvalid), .i_measured_link_delay(dly),
        .o_term_cal_start_a(pul[0]), .o_term_cal_start_b(pul[1]),
        .o_link_cfg(o_link_cfg), .o_link0_run(run0), .o_link1_run(run1),
        .o_first_link_bank(bank0), .o_second_link_bank(bank1),
        .o_class1_rules(cls1), .o_pll_trim(trim));

    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    // one idle cycle before each strobe keeps drives one per time step
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge i_clk);
        #1 req = '{1'b1, 1'b0, a, d};
        @(posedge i_clk);
        #1 req = '0;
    endtask

    task automatic rchk(input logic [11:0] a, input logic [7:0] exp);
        @(posedge i_clk);
        #1 req = '{1'b0, 1'b1, a, 8'h00};
        @(posedge i_clk);
        #1 req = '0;
        chk(o_rvalid, 1'b1);
        chk(o_rdata, exp);
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_table();
        chk({pul, o_rvalid, o_rdata}, 11'h000);
        chk(cls1, 1'b1);
        chk(trim, {RV[0], RV[1], RV[2], RV[3], RV[4], RV[5], RV[6], 8'h00});
        for (int i = 0; i < 12; i++) begin
            rchk(RA[i], RV[i]);
            wr(RA[i], 8'hFF);
            // trim bytes must reach the analog side as written through the writable mask
            if (i < 7) chk(trim[63 - 8 * i -: 8], RM[i]);
            rchk(RA[i], RM[i]);
            wr(RA[i], RV[i]);
        end
        rchk(12'h298, 8'h00);
    endtask

    // a second write of one while high must stay silent
    task automatic t_term(input int k, input logic [11:0] a);
        wr(a, 8'h01);
        chk(pul, 2'h1 << k);
        @(posedge i_clk);
        #1 chk(pul, 2'h0);
        wr(a, 8'h01);
        chk(pul, 2'h0);
        wr(a, 8'h00);
        wr(a, 8'h01);
        chk(pul, 2'h1 << k);
        wr(a, 8'h00);
    endtask

    task automatic t_link();
        logic [7:0] w [6] = '{8'h08, 8'h0A, 8'h02, 8'h45, 8'hFF, 8'h00};
        logic [8:0] e;
        logic [8:0] s;
        // dual mode is chosen before any enable is raised
        for (int i = 0; i < 6; i++) begin
            wr(SPL_OFS_GEN_A, w[i]);
            e = {w[i][6], w[i][3], w[i][2], w[i][1:0], w[i][0],
                 w[i][1] & w[i][3], ~w[i][2], w[i][2]};
            s = {o_link_cfg[7:3], run0, run1, bank0, bank1};
            chk(s, e);
        end
    endtask

    task automatic t_delay();
        dly = 5'h15;
        wr(SPL_OFS_LAT_A, 8'hFF);
        rchk(SPL_OFS_LAT_A, 8'h15);
        dly = 5'h0A;
        wr(12'h298, 8'hFF);
        rchk(SPL_OFS_LAT_A, 8'h0A);
        rchk(12'h298, 8'h00);
    endtask

    task automatic t_class();
        wr(SPL_OFS_GEN_B, 8'hFA);
        rchk(SPL_OFS_GEN_B, 8'h02);
        chk(cls1, 1'b0);
        chk(o_link_cfg[2:0], 3'h2);
        wr(SPL_OFS_GEN_B, 8'h01);
        chk(cls1, 1'b1);
        chk(o_link_cfg[2:0], 3'h1);
    endtask

    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ************************************************************
    // main sequence and watchdog
    // ************************************************************
    initial begin
        repeat (4) @(posedge i_clk);
        #1 i_sys_rst = 1'b0;
        t_table();
        t_term(0, SPL_OFS_TERM_A);
        t_term(1, SPL_OFS_TERM_B);
        t_link();
        t_delay();
        t_class();
        test_done();
    end

    // the run needs about 150 cycles; this is ample margin
    initial begin
        #(40 * 5000);
        fails++;
        test_done();
    end
endmodule

bind spl_regs spl_regs_checker i_chk (.i_clk, .i_sys_rst, .i_req, .o_rdata,
    .o_rvalid, .i_measured_link_delay, .o_term_cal_start_a,
    .o_term_cal_start_b, .o_link_cfg, .o_link0_run, .o_link1_run,
    .o_first_link_bank, .o_second_link_bank, .o_class1_rules);
